// ===== csp_host_model.sv
// host controller model driving the serial control pins
// assumes the bench merges the data line with a pull-up and gives the device priority
`timescale 1ns/1ns
module csp_host_model (
    input wire logic i_core_clk,
    input wire logic i_line,
    output logic o_shift_clk,
    output logic o_data,
    output logic o_data_en,
    output logic o_latch,
    output logic [15:0] o_res_val
);
    event res_ev;

    // idle levels at time zero
    initial begin
        o_shift_clk = 1'b1;
        o_data = 1'b1;
        o_data_en = 1'b0;
        o_latch = 1'b1;
        o_res_val = 16'h0000;
    end

    // quarter link period is two core cycles
    task automatic w(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // data set while the clock is low, taken on its rise
    task automatic put_bit(input logic b);
        w(2);
        o_data = b;
        o_data_en = 1'b1;
        w(2);
        o_shift_clk = 1'b1;
        w(4);
        o_shift_clk = 1'b0;
    endtask

    // 3-wire write frame of n bits, msb first
    task automatic t3_frame(input int n, input logic [23:0] v);
        o_latch = 1'b0;
        w(2);
        o_shift_clk = 1'b0;
        for (int i = n - 1; i >= 0; i--) put_bit(v[i]);
        w(4);
        o_latch = 1'b1;
        w(8);
    endtask

    // 3-wire readback: header, release, sample before each rise
    task automatic t3_read(input logic [6:0] a);
        logic [15:0] word;
        o_latch = 1'b0;
        w(2);
        o_shift_clk = 1'b0;
        put_bit(1'b1);
        for (int i = 6; i >= 0; i--) put_bit(a[i]);
        o_data_en = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            w(4);
            word[i] = i_line;
            o_shift_clk = 1'b1;
            w(4);
            o_shift_clk = 1'b0;
        end
        w(4);
        o_latch = 1'b1;
        w(8);
        o_res_val = word;
        ->res_ev;
    endtask

    // data falls while the clock is high
    task automatic tw_start();
        w(2);
        o_data = 1'b1;
        o_data_en = 1'b1;
        w(2);
        o_shift_clk = 1'b1;
        w(4);
        o_data = 1'b0;
        w(4);
        o_shift_clk = 1'b0;
    endtask

    // data rises while the clock is high
    task automatic tw_stop();
        w(2);
        o_data = 1'b0;
        o_data_en = 1'b1;
        w(2);
        o_shift_clk = 1'b1;
        w(4);
        o_data = 1'b1;
        w(4);
    endtask

    // one byte then the acknowledge slot, reported as a result
    task automatic tw_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        w(2);
        o_data_en = 1'b0;
        w(2);
        o_shift_clk = 1'b1;
        w(2);
        o_res_val = {15'h0000, i_line};
        w(2);
        o_shift_clk = 1'b0;
        ->res_ev;
    endtask
endmodule

// ===== csp_pkg.sv
// constants, carrier types and register defaults of the serial control port
// assumes a 7-bit register address space of 16-bit control registers
package csp_pkg;
    // register map
    localparam int REG_COUNT = 128;
    localparam logic [6:0] REG_RESET_ID = 7'h00;
    localparam logic [6:0] REG_POWER_ONE = 7'h01;
    localparam logic [6:0] REG_GPIO_CTRL = 7'h08;
    localparam logic [6:0] REG_IF_CTRL = 7'h09;
    // field positions
    localparam int GPIO_REPURPOSE_POS = 7;
    localparam int SEQ_WRITE_POS = 1;
    // reset values
    localparam logic [15:0] DEF_ZERO = 16'h0000;
    localparam logic [15:0] DEF_IF_CTRL = 16'h0002;
    // fixed 2-wire device address, binary 0011010
    localparam logic [6:0] DEV_ADDR = 7'h1A;
    // frame and bit counts
    localparam logic [4:0] ALT_FRAME_BITS = 5'h18;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] RB_HDR_LAST = 5'h07;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    // one register write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [15:0] data;
    } csp_wr_t;

    // 2-wire slave states
    typedef enum logic [3:0] {
        TW_IDLE = 4'h1,
        TW_DEV = 4'h2,
        TW_ACK = 4'h4,
        TW_BYTE = 4'h8
    } csp_tw_state_t;

    // default value of each control register
    function automatic logic [15:0] csp_default(input logic [6:0] addr);
        csp_default = (addr == REG_IF_CTRL) ? DEF_IF_CTRL : DEF_ZERO;
    endfunction
endpackage

// ===== csp_serial_ctrl.sv
// serial control port: 3-wire and 2-wire register writes, 3-wire readback
// assumes all pins are asynchronous to i_core_clk; the pad merges the data
// line from o_serial_data_line and o_serial_data_line_oe_n (low = drive)
`timescale 1ns/1ns
module csp_serial_ctrl #(
    parameter logic [15:0] PART_IDENTIFIER = 16'h5A5A, // value is arbitrary
    parameter logic [2:0] SILICON_REVISION_CODE = 3'h1 // value is arbitrary
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_shift_clk,
    input wire logic i_serial_data_line,
    input wire logic i_latch_select_pin,
    input wire logic i_iface_select_pin,
    input wire logic [6:0] i_rd_addr,
    output logic o_serial_data_line,
    output logic o_serial_data_line_oe_n,
    output logic [15:0] o_rd_data,
    output logic o_three_wire,
    output logic o_sw_reset
);
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic sda_rise;
    logic sda_fall;
    logic latch_fall;
    logic latch_rise;
    logic three_wire;
    logic seq_enable;
    logic start_det;
    logic stop_det;
    logic [15:0] regs_reg [0:csp_pkg::REG_COUNT-1];
    csp_pkg::csp_wr_t tw_wr_reg;
    csp_pkg::csp_wr_t t3_wr_reg;
    csp_pkg::csp_wr_t wr;
    logic sw_reset;
    logic [15:0] rd_data_reg;
    logic sw_reset_reg;

    // pin synchronisers; bit order: select, latch, data, clock
    csp_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async({i_iface_select_pin, i_latch_select_pin, i_serial_data_line, i_shift_clk}),
        .o_level(pin_lvl),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // named views of the synchronised pins
    assign scl = pin_lvl[0];
    assign scl_rise = pin_rise[0];
    assign scl_fall = pin_fall[0];
    assign sda = pin_lvl[1];
    assign sda_rise = pin_rise[1];
    assign sda_fall = pin_fall[1];
    assign latch_rise = pin_rise[2];
    assign latch_fall = pin_fall[2];

    // interface mode from the select pin or the repurpose bit, sequential write enable from the register file
    assign three_wire = pin_lvl[3] | regs_reg[csp_pkg::REG_GPIO_CTRL][csp_pkg::GPIO_REPURPOSE_POS];
    assign seq_enable = regs_reg[csp_pkg::REG_IF_CTRL][csp_pkg::SEQ_WRITE_POS];

    // bus conditions seen while the clock is high
    assign start_det = scl & sda_fall;
    assign stop_det = scl & sda_rise;

    // readback contents for the few readable addresses
    function automatic logic [15:0] rb_value(input logic [6:0] addr);
        if (addr == csp_pkg::REG_RESET_ID) begin
            rb_value = PART_IDENTIFIER;
        end else if (addr == csp_pkg::REG_POWER_ONE) begin
            rb_value = {13'h0000, SILICON_REVISION_CODE};
        end else begin
            rb_value = 16'h0000;
        end
    endfunction

    // ---- 3-wire side ----
    logic [23:0] sh3_reg;
    logic [4:0] cnt3_reg;
    logic rd_active_reg;
    logic rd_drive_reg;
    logic rd_bit_reg;
    logic [15:0] rd_sh_reg;
    logic [4:0] rd_cnt_reg;
    logic rb_start;

    // header of eight bits with direction one starts a readback
    assign rb_start = three_wire & scl_rise & (cnt3_reg == csp_pkg::RB_HDR_LAST) & sh3_reg[6];

    // shift register and bit count, restarted when the latch pin falls
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !three_wire || latch_fall) begin
            sh3_reg <= 24'h000000;
            cnt3_reg <= 5'h00;
        end else if (scl_rise) begin
            sh3_reg <= {sh3_reg[22:0], sda};
            if (cnt3_reg != csp_pkg::CNT_MAX) begin
                cnt3_reg <= cnt3_reg + 5'h01;
            end
        end
    end

    // readback: load on header, shift out msb first on clock falls
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !three_wire || latch_rise) begin
            rd_active_reg <= 1'b0;
            rd_drive_reg <= 1'b0;
            rd_bit_reg <= 1'b0;
            rd_sh_reg <= 16'h0000;
            rd_cnt_reg <= 5'h00;
        end else if (rb_start) begin
            rd_active_reg <= 1'b1;
            rd_sh_reg <= rb_value({sh3_reg[5:0], sda});
            rd_cnt_reg <= 5'h00;
        end else if (rd_active_reg && scl_fall) begin
            if (rd_cnt_reg == csp_pkg::WORD_BITS) begin
                rd_drive_reg <= 1'b0; // back to input after last bit
            end else begin
                rd_drive_reg <= 1'b1;
                rd_bit_reg <= rd_sh_reg[15];
                rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
                rd_cnt_reg <= rd_cnt_reg + 5'h01;
            end
        end
    end

    // latch rise commits a write for frames of 16 or more bits unless the frame was a readback
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            t3_wr_reg <= '0;
        end else begin
            t3_wr_reg.en <= 1'b0;
            if (three_wire && latch_rise && !rd_active_reg) begin
                if (cnt3_reg == csp_pkg::ALT_FRAME_BITS && !sh3_reg[23]) begin
                    t3_wr_reg.en <= 1'b1;
                    t3_wr_reg.addr <= sh3_reg[22:16];
                    t3_wr_reg.data <= sh3_reg[15:0];
                end else if (cnt3_reg >= csp_pkg::WORD_BITS) begin
                    t3_wr_reg.en <= 1'b1;
                    t3_wr_reg.addr <= sh3_reg[15:9];
                    t3_wr_reg.data <= {7'h00, sh3_reg[8:0]};
                end
            end
        end
    end

    // ---- 2-wire side ----
    csp_pkg::csp_tw_state_t state_reg;
    logic [2:0] tw_cnt_reg;
    logic [6:0] tw_sh_reg;
    logic ack_on_reg;
    logic [7:0] hi_reg;
    logic byte_idx_reg;
    logic [6:0] seq_addr_reg;
    logic seq_valid_reg;
    logic [7:0] tw_byte;
    logic [6:0] tw_addr;

    // byte completed by the current clock rise
    assign tw_byte = {tw_sh_reg, sda};
    // continued pairs go to the next address when sequential writes are on
    assign tw_addr = (seq_valid_reg && seq_enable) ? seq_addr_reg : hi_reg[7:1];

    // slave state machine
    always_ff @(posedge i_core_clk) begin
        if (i_rst || three_wire) begin
            state_reg <= csp_pkg::TW_IDLE;
            tw_cnt_reg <= 3'h0;
            tw_sh_reg <= 7'h00;
            ack_on_reg <= 1'b0;
            hi_reg <= 8'h00;
            byte_idx_reg <= 1'b0;
            seq_addr_reg <= 7'h00;
            seq_valid_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= csp_pkg::TW_IDLE;
            ack_on_reg <= 1'b0;
        end else if (start_det) begin
            ack_on_reg <= 1'b0;
            tw_cnt_reg <= 3'h0;
            byte_idx_reg <= 1'b0;
            seq_valid_reg <= 1'b0;
            if (state_reg == csp_pkg::TW_IDLE) begin
                state_reg <= csp_pkg::TW_DEV;
            end else begin
                state_reg <= csp_pkg::TW_IDLE;
            end
        end else begin
            case (state_reg)
                csp_pkg::TW_DEV: begin
                    if (scl_rise) begin
                        tw_sh_reg <= tw_byte[6:0];
                        tw_cnt_reg <= tw_cnt_reg + 3'h1;
                        if (tw_cnt_reg == csp_pkg::BYTE_LAST) begin
                            if (tw_byte[7:1] == csp_pkg::DEV_ADDR && !tw_byte[0]) begin
                                state_reg <= csp_pkg::TW_ACK;
                            end else begin
                                state_reg <= csp_pkg::TW_IDLE;
                            end
                        end
                    end
                end
                csp_pkg::TW_BYTE: begin
                    if (scl_rise) begin
                        tw_sh_reg <= tw_byte[6:0];
                        tw_cnt_reg <= tw_cnt_reg + 3'h1;
                        if (tw_cnt_reg == csp_pkg::BYTE_LAST) begin
                            state_reg <= csp_pkg::TW_ACK;
                            byte_idx_reg <= ~byte_idx_reg;
                            if (!byte_idx_reg) begin
                                hi_reg <= tw_byte;
                            end else begin
                                seq_addr_reg <= tw_addr + 7'h01;
                                seq_valid_reg <= 1'b1;
                            end
                        end
                    end
                end
                csp_pkg::TW_ACK: begin
                    // drive low for the one clock pulse after the byte
                    if (scl_fall) begin
                        if (!ack_on_reg) begin
                            ack_on_reg <= 1'b1;
                        end else begin
                            ack_on_reg <= 1'b0;
                            state_reg <= csp_pkg::TW_BYTE;
                            tw_cnt_reg <= 3'h0;
                        end
                    end
                end
                default: begin
                    state_reg <= csp_pkg::TW_IDLE;
                end
            endcase
        end
    end

    // second byte of a pair issues the write
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tw_wr_reg <= '0;
        end else begin
            tw_wr_reg.en <= 1'b0;
            if (!three_wire && !start_det && !stop_det && state_reg == csp_pkg::TW_BYTE
                && scl_rise && tw_cnt_reg == csp_pkg::BYTE_LAST && byte_idx_reg) begin
                tw_wr_reg.en <= 1'b1;
                tw_wr_reg.addr <= tw_addr;
                tw_wr_reg.data <= {7'h00, hi_reg[0], tw_byte};
            end
        end
    end

    // ---- register file ----
    assign wr = tw_wr_reg.en ? tw_wr_reg : t3_wr_reg;
    assign sw_reset = wr.en && (wr.addr == csp_pkg::REG_RESET_ID);

    // reset and register-zero writes load defaults, others store
    always_ff @(posedge i_core_clk) begin
        if (i_rst || sw_reset) begin
            for (int i = 0; i < csp_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= csp_pkg::csp_default(7'(i));
            end
        end else if (wr.en) begin
            regs_reg[wr.addr] <= wr.data;
        end
    end

    // internal read port and reset pulse for the rest of the chip
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rd_data_reg <= 16'h0000;
            sw_reset_reg <= 1'b0;
        end else begin
            rd_data_reg <= regs_reg[i_rd_addr];
            sw_reset_reg <= sw_reset;
        end
    end

    // outputs
    assign o_rd_data = rd_data_reg;
    assign o_sw_reset = sw_reset_reg;
    assign o_three_wire = three_wire;
    assign o_serial_data_line = rd_bit_reg & ~ack_on_reg;
    assign o_serial_data_line_oe_n = ~(ack_on_reg | rd_drive_reg);

    // ---- checks ----
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_shift_capture: assert property (three_wire && scl_rise && !latch_fall
        |=> sh3_reg[0] == $past(sda))
        else $error("3-wire bit not captured");
    a_latch_commit: assert property (three_wire && latch_rise && !rd_active_reg
        && cnt3_reg == 5'h10 |=> t3_wr_reg.en && t3_wr_reg.addr == $past(sh3_reg[15:9]))
        else $error("latch did not commit word");
    a_read_ident: assert property (rb_start && {sh3_reg[5:0], sda} == 7'h00
        |=> rd_sh_reg == PART_IDENTIFIER)
        else $error("identifier readback wrong");
    a_read_revision: assert property (rb_start && {sh3_reg[5:0], sda} == 7'h01
        |=> rd_sh_reg[2:0] == SILICON_REVISION_CODE)
        else $error("revision readback wrong");
    a_start_entry: assert property (!three_wire && start_det && !stop_det
        && state_reg == csp_pkg::TW_IDLE |=> state_reg == csp_pkg::TW_DEV)
        else $error("start not detected");
    a_ack_drive: assert property (ack_on_reg |-> !o_serial_data_line_oe_n
        && !o_serial_data_line)
        else $error("acknowledge not driven low");
    a_addr_reject: assert property (!three_wire && !start_det && !stop_det
        && state_reg == csp_pkg::TW_DEV && scl_rise && tw_cnt_reg == 3'h7
        && tw_byte != {csp_pkg::DEV_ADDR, 1'b0} |=> state_reg == csp_pkg::TW_IDLE)
        else $error("mismatched address not dropped");
    a_stop_idle: assert property (!three_wire && stop_det
        |=> state_reg == csp_pkg::TW_IDLE && !ack_on_reg)
        else $error("stop did not end transfer");
    a_oos_idle: assert property (!three_wire && start_det && !stop_det
        && state_reg != csp_pkg::TW_IDLE |=> state_reg == csp_pkg::TW_IDLE)
        else $error("out-of-sequence start not honoured");
    a_soft_reset: assert property (sw_reset
        |=> regs_reg[csp_pkg::REG_IF_CTRL] == csp_pkg::DEF_IF_CTRL && o_sw_reset)
        else $error("register-zero write did not restore defaults");
    a_write_store: assert property (wr.en && wr.addr != 7'h00
        |=> regs_reg[$past(wr.addr)] == $past(wr.data))
        else $error("write not stored");
    a_mode_select: assert property (!pin_lvl[3]
        && !regs_reg[csp_pkg::REG_GPIO_CTRL][csp_pkg::GPIO_REPURPOSE_POS] |-> !o_three_wire)
        else $error("2-wire mode not selected");

    c_two_wire_write: cover property (tw_wr_reg.en);
    c_three_wire_write: cover property (t3_wr_reg.en);
    c_readback: cover property (rd_drive_reg ##1 !rd_drive_reg);
    c_soft_reset: cover property (sw_reset);
endmodule

// ===== csp_serial_ctrl_test.sv
// self-checking bench of the serial control port in both pin modes
// assumes the host model file is compiled first
`timescale 1ns/1ns
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (got), (exp)); end end
module csp_serial_ctrl_test;
    localparam logic [15:0] TB_PART_ID = 16'hC3A5; // value is arbitrary
    localparam logic [2:0] TB_REV = 3'h5; // value is arbitrary
    localparam logic [6:0] TB_VOL_REG = 7'h36; // stand-in volume register, value is arbitrary
    logic i_core_clk;
    logic i_rst;
    logic i_iface_select_pin;
    logic rd_stb;
    logic [6:0] i_rd_addr;
    logic o_serial_data_line, o_serial_data_line_oe_n, o_three_wire, o_sw_reset;
    logic [15:0] o_rd_data, d, e, res_val, e_rd, e_rs, e_sw;
    logic sclk;
    logic h_dat;
    logic h_en;
    logic latch;
    wire line;
    int err_count, samples_checked;
    logic [15:0] exp_q[$];

    // pad merge: device drive wins, pull-up when released
    assign line = (o_serial_data_line_oe_n === 1'b0) ? o_serial_data_line : (h_en ? h_dat : 1'b1);

    csp_serial_ctrl #(.PART_IDENTIFIER(TB_PART_ID), .SILICON_REVISION_CODE(TB_REV)) u_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_shift_clk(sclk),
        .i_serial_data_line(line), .i_latch_select_pin(latch),
        .i_iface_select_pin(i_iface_select_pin), .i_rd_addr(i_rd_addr),
        .o_serial_data_line(o_serial_data_line),
        .o_serial_data_line_oe_n(o_serial_data_line_oe_n), .o_rd_data(o_rd_data),
        .o_three_wire(o_three_wire), .o_sw_reset(o_sw_reset));

    csp_host_model u_host (
        .i_core_clk(i_core_clk), .i_line(line), .o_shift_clk(sclk), .o_data(h_dat),
        .o_data_en(h_en), .o_latch(latch), .o_res_val(res_val));

    // 25 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    function automatic logic [15:0] pop_exp();
        if (exp_q.size() == 0) return 16'hXXXX;
        return exp_q.pop_front();
    endfunction

    // result monitors take the oldest expectation
    always @(negedge i_core_clk) if (rd_stb) begin
        e_rd = pop_exp();
        `CHECK(o_rd_data, e_rd)
    end
    always @(u_host.res_ev) begin
        e_rs = pop_exp();
        `CHECK(res_val, e_rs)
    end
    always @(negedge i_core_clk) if (o_sw_reset === 1'b1) begin
        e_sw = pop_exp();
        `CHECK(16'h0001, e_sw)
    end

    task automatic rd_reg(input logic [6:0] a, input logic [15:0] v);
        exp_q.push_back(v);
        @(negedge i_core_clk);
        i_rd_addr <= a;
        rd_stb <= 1'b1;
        @(negedge i_core_clk);
        rd_stb <= 1'b0;
        i_rd_addr <= 7'($urandom()); // idle port address wanders
        @(negedge i_core_clk);
    endtask

    task automatic tb_byte(input logic [7:0] b, input logic ack);
        exp_q.push_back({15'h0000, ack});
        u_host.tw_byte(b);
    endtask

    task automatic end_of_test();
        if (exp_q.size() != 0) err_count++;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        i_rst = 1'b1;
        i_iface_select_pin = 1'b1;
        i_rd_addr = 7'h00;
        rd_stb = 1'b0;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'h2366));
        repeat (12) @(negedge i_core_clk);
        i_rst = 1'b0;
        u_host.w(4);
        rd_reg(7'h09, 16'h0002);
        rd_reg(7'h08, 16'h0000);
        rd_reg(7'h01, 16'h0000);
        `CHECK(o_three_wire, 1'b1)
        // power-up habit: software reset first, then volume steps
        exp_q.push_back(16'h0001);
        u_host.t3_frame(24, {1'b0, 7'h00, 16'h0000});
        for (int i = 1; i <= 3; i++) u_host.t3_frame(24, {1'b0, TB_VOL_REG, 16'(i)});
        rd_reg(TB_VOL_REG, 16'h0003);
        d = 16'($urandom());
        e = 16'($urandom());
        // 3-wire framed, plain 16-bit and short refused frames
        u_host.t3_frame(24, {1'b0, 7'h02, d});
        rd_reg(7'h02, d);
        u_host.t3_frame(16, {8'h00, 7'h03, e[8:0]});
        rd_reg(7'h03, {7'h00, e[8:0]});
        u_host.t3_frame(10, 24'h0001FF);
        rd_reg(7'h03, {7'h00, e[8:0]});
        // readback of identifier, revision and an unreadable place
        exp_q.push_back(TB_PART_ID);
        u_host.t3_read(7'h00);
        exp_q.push_back({13'h0000, TB_REV});
        u_host.t3_read(7'h01);
        exp_q.push_back(16'h0000);
        u_host.t3_read(7'h02);
        // 2-wire sequential pair write
        i_iface_select_pin = 1'b0;
        u_host.w(4);
        `CHECK(o_three_wire, 1'b0)
        u_host.tw_start();
        tb_byte(8'h34, 1'b0);
        tb_byte({7'h05, d[8]}, 1'b0);
        tb_byte(d[7:0], 1'b0);
        tb_byte({7'h00, e[8]}, 1'b0);
        tb_byte(e[7:0], 1'b0);
        u_host.tw_stop();
        rd_reg(7'h05, {7'h00, d[8:0]});
        rd_reg(7'h06, {7'h00, e[8:0]});
        // foreign address and read direction are not acknowledged
        u_host.tw_start();
        tb_byte(8'h36, 1'b1);
        u_host.tw_stop();
        u_host.tw_start();
        tb_byte(8'h35, 1'b1);
        u_host.tw_stop();
        // start in mid-transfer drops the pending write
        u_host.tw_start();
        tb_byte(8'h34, 1'b0);
        tb_byte({7'h05, ~d[8]}, 1'b0);
        u_host.tw_start();
        tb_byte(8'h00, 1'b1);
        u_host.tw_stop();
        rd_reg(7'h05, {7'h00, d[8:0]});
        // reset in mid-run with the link idle brings defaults back
        i_rst = 1'b1;
        u_host.w(4);
        i_rst = 1'b0;
        u_host.w(4);
        rd_reg(7'h05, 16'h0000);
        rd_reg(7'h09, 16'h0002);
        // repurpose bit forces 3-wire, software reset restores defaults
        u_host.tw_start();
        tb_byte(8'h34, 1'b0);
        tb_byte({7'h08, 1'b0}, 1'b0);
        tb_byte(8'h80, 1'b1);
        u_host.tw_stop();
        `CHECK(o_three_wire, 1'b1)
        u_host.t3_frame(24, {1'b0, 7'h07, d});
        rd_reg(7'h07, d);
        exp_q.push_back(16'h0001);
        u_host.t3_frame(24, {1'b0, 7'h00, 16'hFFFF});
        rd_reg(7'h07, 16'h0000);
        rd_reg(7'h08, 16'h0000);
        rd_reg(7'h09, 16'h0002);
        u_host.tw_start();
        tb_byte(8'h34, 1'b0);
        tb_byte(8'h00, 1'b0);
        exp_q.push_back(16'h0001);
        tb_byte(8'h00, 1'b0);
        u_host.tw_stop();
        u_host.w(8);
        end_of_test();
    end
endmodule

// ===== csp_sync.sv
// two-flop synchroniser with edge detection for a group of pin inputs
// assumes inputs idle high (pulled-up bus lines)
`timescale 1ns/1ns
module csp_sync #(
    parameter int WIDTH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    // first stage feeds only the second
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_reg <= '1;
            sync_reg <= '1;
            last_reg <= '1;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges from the settled copies
    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~last_reg;
    assign o_fall = ~sync_reg & last_reg;
endmodule
